// ### core/rdw_pkg.sv
// Shared constants and types of the receive descriptor write-back engine.
// Assumes a 32-bit host memory path and a classic Wishbone register slave.
package rdw_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned WB_AW      = 8;
    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_BASE   = 8'h04;
    localparam logic [7:0]  REG_CUR    = 8'h08;
    localparam logic [7:0]  REG_ISTAT  = 8'h0c;
    localparam logic [7:0]  REG_IMASK  = 8'h10;
    localparam logic [7:0]  REG_STATE  = 8'h14;

    localparam int unsigned CTRL_EN    = 0;
    localparam int unsigned CTRL_PASS  = 1;
    localparam int unsigned CTRL_POLL  = 2;
    localparam logic [1:0]  CTRL_RST   = 2'h0;
    localparam logic [31:0] BASE_RST   = 32'h0;

    localparam int unsigned IRQ_W      = 3;
    localparam int unsigned IRQ_FRAME  = 0;
    localparam int unsigned IRQ_NODESC = 1;
    localparam int unsigned IRQ_DROP   = 2;
    localparam logic [2:0]  IMASK_RST  = 3'h0;

    // ------------------------------------------------------------
    // Descriptor layout
    // ------------------------------------------------------------
    localparam logic [31:0] DESC_W1    = 32'h4;
    localparam logic [31:0] DESC_W2    = 32'h8;
    localparam logic [31:0] DESC_W3    = 32'hc;
    localparam logic [31:0] WORD_BYTES = 32'h4;

    localparam int unsigned W0_OWN     = 31;
    localparam int unsigned W0_FIRST   = 30;
    localparam int unsigned W0_LAST    = 29;
    localparam int unsigned W0_ERRSUM  = 25;
    localparam int unsigned W0_MCAST   = 24;
    localparam int unsigned W0_PORT    = 20;
    localparam int unsigned PORT_W     = 4;
    localparam int unsigned W0_PHY     = 19;
    localparam int unsigned W0_OVER    = 18;
    localparam int unsigned W0_RUNT    = 17;
    localparam int unsigned W0_CRC     = 16;
    localparam int unsigned W0_KIND    = 15;
    localparam int unsigned W0_LEN     = 0;
    localparam int unsigned LEN_W      = 11;
    localparam int unsigned W1_WRAP    = 25;
    localparam int unsigned RBS_W      = 12;

    localparam logic [15:0] MAX_FRAME  = 16'd1518;
    localparam logic [15:0] TYPE_MIN   = 16'd1500;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_RD0   = 4'h1,
        ST_RD1   = 4'h2,
        ST_RD2   = 4'h3,
        ST_RD3   = 4'h4,
        ST_DATA  = 4'h5,
        ST_WDATA = 4'h6,
        ST_WSTAT = 4'h7,
        ST_STALL = 4'h8
    } rdw_state_e;

    typedef struct packed {
        logic        multicast;
        logic [1:0]  port;
        logic        phy_fault;
        logic        crc_err;
        logic        runt;
        logic [15:0] len_type;
    } rdw_rxstat_s;

    typedef struct packed {
        logic        enable;
        logic        pass_bad;
        logic [31:0] list_base;
    } rdw_ctrl_s;

endpackage

// ### core/rdw_regs.sv
// Wishbone register slave with interrupt status and mask.
// Assumes a classic single-cycle master; answers one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module rdw_regs
    import rdw_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [WB_AW-1:0]        wb_adr,
    input  wire logic [31:0]             wb_dat_i,
    input  wire logic [3:0]              wb_sel,
    input  wire logic                    wb_we,
    input  wire logic                    wb_cyc,
    input  wire logic                    wb_stb,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack,
    output rdw_pkg::rdw_ctrl_s           ctrl,
    output logic                         poll,
    input  wire logic [IRQ_W-1:0]        event_set,
    input  wire logic [31:0]             cur_desc,
    input  wire logic [3:0]              state_code,
    output logic                         irq
);

    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic             wr;
    logic             rd;

    assign wr = wb_cyc && wb_stb && wb_we && !wb_ack;
    assign rd = wb_cyc && wb_stb && !wb_we && !wb_ack;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack <= 1'b0;
        end else begin
            wb_ack <= wb_cyc && wb_stb && !wb_ack;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl.enable    <= CTRL_RST[CTRL_EN];
            ctrl.pass_bad  <= CTRL_RST[CTRL_PASS];
            ctrl.list_base <= BASE_RST;
            imask          <= IMASK_RST;
            poll           <= 1'b0;
        end else begin
            poll <= 1'b0;
            if (wr && wb_adr == REG_CTRL && wb_sel[0]) begin
                ctrl.enable   <= wb_dat_i[CTRL_EN];
                ctrl.pass_bad <= wb_dat_i[CTRL_PASS];
                poll          <= wb_dat_i[CTRL_POLL];
            end
            if (wr && wb_adr == REG_BASE) begin
                ctrl.list_base <= merge(ctrl.list_base, wb_dat_i, wb_sel);
            end
            if (wr && wb_adr == REG_IMASK && wb_sel[0]) begin
                imask <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    // A hardware event in the same cycle as a clearing write stays set.
    always_ff @(posedge clk) begin
        if (rst) begin
            istat <= '0;
        end else if (wr && wb_adr == REG_ISTAT && wb_sel[0]) begin
            istat <= (istat & ~wb_dat_i[IRQ_W-1:0]) | event_set;
        end else begin
            istat <= istat | event_set;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(istat & imask);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0;
        end else if (rd) begin
            unique case (wb_adr)
                REG_CTRL:  wb_dat_o <= {30'h0, ctrl.pass_bad, ctrl.enable};
                REG_BASE:  wb_dat_o <= ctrl.list_base;
                REG_CUR:   wb_dat_o <= cur_desc;
                REG_ISTAT: wb_dat_o <= {29'h0, istat};
                REG_IMASK: wb_dat_o <= {29'h0, imask};
                REG_STATE: wb_dat_o <= {28'h0, state_code};
                default:   wb_dat_o <= 32'h0;
            endcase
        end
    end

endmodule
`default_nettype wire

// ### core/rdw_engine.sv
// Receive descriptor engine: walks the host descriptor chain, stores frame
// words into host buffers and writes the status word back.
// Assumes a host memory port that acknowledges each request with one pulse
// and a receive stream that presents one 32-bit word per handshake.
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

// How it works
// R01: error summary ORs crc, oversize, runt
// R02: multicast flag on the last descriptor
// R03: ingress port in four-bit field
// R04: phy fault seen anywhere in frame
// R05: oversize above 1518, never truncated
// R06: runts dropped unless pass-bad is set
// R07: crc mismatch flag on last descriptor
// R08: frame kind set above 1500 unless runt
// R09: eleven-bit byte count including crc
// R10: ring-end marker wraps to list base
// R11: twelve-bit size, zero size skipped
// R12: host gives sizes in multiples of four
// R13: third word holds aligned buffer address
// R14: fourth word holds next descriptor address
// R15: only owned descriptors used, ownership returned
// R16: first-buffer mark where frame starts
// R17: last-buffer mark carries final status
// R18: whole status word in one write
module rdw_engine
    import rdw_pkg::*;
(
    input  wire logic                    CLOCK,
    input  wire logic                    SYS_RST,
    input  wire logic [WB_AW-1:0]        WB_ADR_I,
    input  wire logic [31:0]             WB_DAT_I,
    input  wire logic [3:0]              WB_SEL_I,
    input  wire logic                    WB_WE_I,
    input  wire logic                    WB_CYC_I,
    input  wire logic                    WB_STB_I,
    output logic      [31:0]             WB_DAT_O,
    output logic                         WB_ACK_O,
    output logic                         IRQ,
    output logic                         MEM_REQ,
    output logic                         MEM_WE,
    output logic      [31:0]             MEM_ADDR,
    output logic      [31:0]             MEM_WDATA,
    input  wire logic [31:0]             MEM_RDATA,
    input  wire logic                    MEM_ACK,
    input  wire logic                    RX_VALID,
    output logic                         RX_READY,
    input  wire logic [31:0]             RX_DATA,
    input  wire logic [2:0]              RX_BYTES,
    input  wire logic                    RX_LAST,
    input  wire rdw_pkg::rdw_rxstat_s    RX_STAT
);

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    rdw_ctrl_s        ctrl;
    logic             poll;
    logic [IRQ_W-1:0] events;
    rdw_state_e       state;
    logic [31:0]      cur;
    logic [31:0]      frame_start;
    logic             wrap;
    logic [RBS_W-1:0] buf_size;
    logic [31:0]      buf_addr;
    logic [31:0]      next_desc;
    logic [RBS_W-1:0] offset;
    logic [15:0]      byte_count;
    logic             in_frame;
    logic             buf_first;
    logic             buf_last;
    logic             phy_seen;
    rdw_rxstat_s      stat;
    logic             take;
    logic             drop;
    logic             buf_full;
    logic             oversize;
    logic [31:0]      status_word;

    rdw_regs u_regs (
        .clk        (CLOCK),
        .rst        (SYS_RST),
        .wb_adr     (WB_ADR_I),
        .wb_dat_i   (WB_DAT_I),
        .wb_sel     (WB_SEL_I),
        .wb_we      (WB_WE_I),
        .wb_cyc     (WB_CYC_I),
        .wb_stb     (WB_STB_I),
        .wb_dat_o   (WB_DAT_O),
        .wb_ack     (WB_ACK_O),
        .ctrl       (ctrl),
        .poll       (poll),
        .event_set  (events),
        .cur_desc   (cur),
        .state_code (state),
        .irq        (IRQ)
    );

    // ------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------
    assign take     = (state == ST_DATA) && RX_VALID && RX_READY;
    assign drop     = stat.runt && !ctrl.pass_bad; // see R06
    assign buf_full = (offset + RBS_W'(WORD_BYTES)) >= buf_size; // see R12
    assign oversize = byte_count > MAX_FRAME; // see R05

    // Status word: the frame fields except the phy fault go only into the last descriptor.
    always_comb begin
        status_word           = 32'h0;
        status_word[W0_OWN]   = 1'b0; // see R15
        status_word[W0_FIRST] = buf_first; // see R16
        status_word[W0_LAST]  = buf_last; // see R17
        if (buf_last) begin
            status_word[W0_ERRSUM] = stat.crc_err || oversize || stat.runt; // see R01
            status_word[W0_MCAST]  = stat.multicast; // see R02
            status_word[W0_PORT +: PORT_W] = {2'b00, stat.port}; // see R03
            status_word[W0_OVER]   = oversize; // see R05
            status_word[W0_RUNT]   = stat.runt; // see R06
            status_word[W0_CRC]    = stat.crc_err; // see R07
            status_word[W0_KIND]   = !stat.runt && (stat.len_type > TYPE_MIN); // see R08
            status_word[W0_LEN +: LEN_W] = byte_count[LEN_W-1:0]; // see R09
        end
        status_word[W0_PHY] = phy_seen; // see R04
    end

    // ------------------------------------------------------------
    // Descriptor walk and data transfer
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            state     <= ST_IDLE;
            cur       <= 32'h0;
            MEM_REQ   <= 1'b0;
            MEM_WE    <= 1'b0;
            MEM_ADDR  <= 32'h0;
            MEM_WDATA <= 32'h0;
            RX_READY  <= 1'b0;
            wrap      <= 1'b0;
            buf_size  <= '0;
            buf_addr  <= 32'h0;
            next_desc <= 32'h0;
            offset    <= '0;
            buf_first <= 1'b0;
            buf_last  <= 1'b0;
        end else if (!ctrl.enable) begin
            state    <= ST_IDLE;
            cur      <= ctrl.list_base;
            MEM_REQ  <= 1'b0;
            RX_READY <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    state <= ST_RD0;
                end
                ST_RD0: begin
                    if (MEM_ACK) begin
                        MEM_REQ <= 1'b0;
                        if (MEM_RDATA[W0_OWN]) begin // see R15
                            state <= ST_RD1;
                        end else begin
                            state <= ST_STALL;
                        end
                    end else if (!MEM_REQ) begin
                        MEM_REQ  <= 1'b1;
                        MEM_WE   <= 1'b0;
                        MEM_ADDR <= cur;
                    end
                end
                ST_RD1: begin
                    if (MEM_ACK) begin
                        MEM_REQ  <= 1'b0;
                        wrap     <= MEM_RDATA[W1_WRAP]; // see R10
                        buf_size <= MEM_RDATA[RBS_W-1:0]; // see R11
                        state    <= ST_RD2;
                    end else if (!MEM_REQ) begin
                        MEM_REQ  <= 1'b1;
                        MEM_ADDR <= cur + DESC_W1;
                    end
                end
                ST_RD2: begin
                    if (MEM_ACK) begin
                        MEM_REQ  <= 1'b0;
                        buf_addr <= MEM_RDATA; // see R13
                        state    <= ST_RD3;
                    end else if (!MEM_REQ) begin
                        MEM_REQ  <= 1'b1;
                        MEM_ADDR <= cur + DESC_W2;
                    end
                end
                ST_RD3: begin
                    if (MEM_ACK) begin
                        MEM_REQ   <= 1'b0;
                        next_desc <= MEM_RDATA; // see R14
                        offset    <= '0;
                        buf_first <= 1'b0;
                        buf_last  <= 1'b0;
                        if (buf_size == '0) begin
                            // Empty buffer: leave it untouched and move on.
                            cur   <= wrap ? ctrl.list_base : MEM_RDATA; // see R11
                            state <= ST_RD0;
                        end else begin
                            state <= ST_DATA;
                        end
                    end else if (!MEM_REQ) begin
                        MEM_REQ  <= 1'b1;
                        MEM_ADDR <= cur + DESC_W3;
                    end
                end
                ST_DATA: begin
                    if (take) begin
                        RX_READY  <= 1'b0;
                        MEM_REQ   <= 1'b1;
                        MEM_WE    <= 1'b1;
                        MEM_ADDR  <= buf_addr + 32'(offset);
                        MEM_WDATA <= RX_DATA;
                        buf_last  <= RX_LAST; // see R17
                        if (!in_frame) begin
                            buf_first <= 1'b1; // see R16
                        end
                        state <= ST_WDATA;
                    end else begin
                        RX_READY <= 1'b1;
                    end
                end
                ST_WDATA: begin
                    if (MEM_ACK) begin
                        MEM_REQ <= 1'b0;
                        offset  <= offset + RBS_W'(WORD_BYTES);
                        if (buf_last && drop) begin
                            // Discarded frame: reuse its descriptors.
                            cur   <= frame_start; // see R06
                            state <= ST_RD0;
                        end else if (buf_last || buf_full) begin
                            state <= ST_WSTAT;
                        end else begin
                            state <= ST_DATA;
                        end
                    end
                end
                ST_WSTAT: begin
                    if (MEM_ACK) begin
                        MEM_REQ <= 1'b0;
                        cur     <= wrap ? ctrl.list_base : next_desc; // see R10
                        state   <= ST_RD0;
                    end else if (!MEM_REQ) begin
                        // One write of the full word after the data is stored.
                        MEM_REQ   <= 1'b1;
                        MEM_WE    <= 1'b1;
                        MEM_ADDR  <= cur;
                        MEM_WDATA <= status_word; // see R18
                    end
                end
                ST_STALL: begin
                    if (poll) begin
                        state <= ST_RD0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Frame tracking and accumulated status
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || !ctrl.enable) begin
            in_frame    <= 1'b0;
            frame_start <= 32'h0;
            byte_count  <= 16'h0;
            phy_seen    <= 1'b0;
            stat        <= '0;
        end else if (take) begin
            if (!in_frame) begin
                frame_start <= cur;
                byte_count  <= 16'(RX_BYTES);
                phy_seen    <= RX_STAT.phy_fault; // see R04
            end else begin
                // The count keeps running past the limit; nothing is cut.
                byte_count  <= byte_count + 16'(RX_BYTES); // see R05
                phy_seen    <= phy_seen | RX_STAT.phy_fault; // see R04
            end
            in_frame <= !RX_LAST;
            if (RX_LAST) begin
                stat <= RX_STAT;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            events <= '0;
        end else begin
            events             <= '0;
            events[IRQ_FRAME]  <= (state == ST_WSTAT) && MEM_ACK && buf_last;
            events[IRQ_NODESC] <= (state == ST_RD0) && MEM_ACK && !MEM_RDATA[W0_OWN];
            events[IRQ_DROP]   <= (state == ST_WDATA) && MEM_ACK && buf_last && drop;
        end
    end

endmodule
`default_nettype wire

// ### dv/rdw_sva.sv
// Port-level checks of the receive descriptor engine.
// Assumes one clock domain and the bind statement at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module rdw_sva
    import rdw_pkg::*;
(
    input wire logic             CLOCK,
    input wire logic             SYS_RST,
    input wire logic [WB_AW-1:0] WB_ADR_I,
    input wire logic             WB_WE_I,
    input wire logic             WB_CYC_I,
    input wire logic             WB_STB_I,
    input wire logic [31:0]      WB_DAT_O,
    input wire logic             WB_ACK_O,
    input wire logic             MEM_REQ,
    input wire logic             MEM_WE,
    input wire logic [31:0]      MEM_ADDR,
    input wire logic [31:0]      MEM_WDATA,
    input wire logic             MEM_ACK,
    input wire logic             RX_VALID,
    input wire logic             RX_READY
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    sequence s_wb_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_taken;
        RX_VALID && RX_READY;
    endsequence
    a_wb_answer: assert property (s_wb_req |=> WB_ACK_O)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_unmapped_zero: assert property (s_wb_req and (!WB_WE_I && WB_ADR_I > 8'h14)
        |=> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    a_mem_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR)
        && $stable(MEM_WE) && $stable(MEM_WDATA))
        else $error("memory request changed before ack");
    a_mem_release: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ)
        else $error("memory request kept after ack");
    a_addr_aligned: assert property (MEM_REQ |-> MEM_ADDR[1:0] == 2'h0)
        else $error("memory address not word aligned");
    a_ready_drop: assert property (s_taken |=> !RX_READY)
        else $error("ready kept after word taken");
    a_word_stored: assert property (s_taken |=> MEM_REQ && MEM_WE)
        else $error("taken word not written to memory");
endmodule
bind rdw_engine rdw_sva i_sva (.CLOCK, .SYS_RST, .WB_ADR_I, .WB_WE_I, .WB_CYC_I,
    .WB_STB_I, .WB_DAT_O, .WB_ACK_O, .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_WDATA,
    .MEM_ACK, .RX_VALID, .RX_READY);
`default_nettype wire

// ### dv/rdw_mem_model.sv
// Host memory model behind the engine's memory port.
// Assumes word-aligned byte addresses; answers alternately after one and three cycles.
`timescale 1ns/1ns
`default_nettype none
module rdw_mem_model (
    input  wire logic        CLOCK,
    input  wire logic        MEM_REQ,
    input  wire logic        MEM_WE,
    input  wire logic [31:0] MEM_ADDR,
    input  wire logic [31:0] MEM_WDATA,
    output logic      [31:0] MEM_RDATA = 32'h0,
    output logic             MEM_ACK = 1'b0
);
    logic [31:0] mem [logic [31:0]];
    logic [1:0]  cnt = 2'h0;
    logic [1:0]  lat = 2'h0;
    // Read data is only meaningful in the ack cycle, so it toggles otherwise.
    always @(posedge CLOCK) begin
        MEM_ACK <= 1'b0;
        MEM_RDATA <= ~MEM_RDATA;
        if (MEM_REQ && !MEM_ACK) begin
            if (cnt == lat) begin
                MEM_ACK <= 1'b1;
                cnt <= 2'h0;
                lat <= lat ^ 2'h2;
                if (MEM_WE) mem[MEM_ADDR] = MEM_WDATA;
                else MEM_RDATA <= mem[MEM_ADDR];
            end else cnt <= cnt + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench: registers over Wishbone, frames over the stream.
// Assumes host memory is the model in rdw_mem_model.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import rdw_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, wwe = 1'b0, wcyc = 1'b0, rvld = 1'b0, rlast = 1'b0;
    logic        ack, irq, mreq, mwe, mack, rrdy;
    logic [7:0]  wadr = 8'h0;
    logic [31:0] wdat = 32'h0, rdata = 32'h0, rdat, mrd, madr, mwd, v;
    logic [2:0]  rbytes = 3'h4;
    rdw_rxstat_s rstat = '0;
    int          num_errors = 0, checks_done = 0, ticks = 0;
    rdw_engine i_dut (.CLOCK(clk), .SYS_RST(rst), .WB_ADR_I(wadr), .WB_DAT_I(wdat),
        .WB_SEL_I(4'hf), .WB_WE_I(wwe), .WB_CYC_I(wcyc), .WB_STB_I(wcyc), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .IRQ(irq), .MEM_REQ(mreq), .MEM_WE(mwe), .MEM_ADDR(madr),
        .MEM_WDATA(mwd), .MEM_RDATA(mrd), .MEM_ACK(mack), .RX_VALID(rvld), .RX_READY(rrdy),
        .RX_DATA(rdata), .RX_BYTES(rbytes), .RX_LAST(rlast), .RX_STAT(rstat));
    rdw_mem_model i_mem (.CLOCK(clk), .MEM_REQ(mreq), .MEM_WE(mwe), .MEM_ADDR(madr),
        .MEM_WDATA(mwd), .MEM_RDATA(mrd), .MEM_ACK(mack));
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wcyc <= 1'b1;
        wwe <= we;
        wadr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        v = rdat;
        wcyc <= 1'b0;
        wwe <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(n, e, v);
    endtask
    task automatic pollst(input int k);
        v = 32'h0;
        for (int i = 0; i < 60 && v[k] !== 1'b1; i++) wb(1'b0, REG_ISTAT, 32'h0);
        chk("istat", 32'h1, {31'h0, v[k]});
    endtask
    task automatic waitirq;
        for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
    endtask
    task automatic rx(input logic [31:0] d, input logic [2:0] b, input logic l,
                      input logic [21:0] s);
        @(posedge clk);
        rvld <= 1'b1;
        rdata <= d;
        rbytes <= b;
        rlast <= l;
        rstat <= s;
        do @(posedge clk); while (rrdy !== 1'b1);
        rvld <= 1'b0;
        rdata <= ~d;
    endtask
    task automatic desc(input logic [31:0] a, w0, w1, w2, w3);
        i_mem.mem[a] = w0;
        i_mem.mem[a + DESC_W1] = w1;
        i_mem.mem[a + DESC_W2] = w2;
        i_mem.mem[a + DESC_W3] = w3;
    endtask
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        ticks++;
        if (ticks == 20000) begin
            num_errors++;
            print_verdict;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rchk("ctrl", REG_CTRL, 32'h0);
        rchk("base", REG_BASE, BASE_RST);
        rchk("mask", REG_IMASK, 32'h0);
        rchk("unmapped", 8'h40, 32'h0);
        desc(32'h100, 32'h0, 32'h8, 32'h400, 32'h110);
        desc(32'h110, 32'h8000_0000, 32'h0, 32'h480, 32'h120);
        desc(32'h120, 32'h8000_0000, 32'h0200_0010, 32'h500, 32'h900);
        wb(1'b1, REG_BASE, 32'h100);
        rchk("base", REG_BASE, 32'h100);
        wb(1'b1, REG_IMASK, 32'h1);
        wb(1'b1, REG_CTRL, 32'h1);
        pollst(IRQ_NODESC);
        wb(1'b1, REG_ISTAT, 32'h2);
        i_mem.mem[32'h100] = 32'h8000_0000;
        wb(1'b1, REG_CTRL, 32'h5);
        rx(32'h11, 3'h4, 1'b0, 22'h04_0000);
        rx(32'h22, 3'h4, 1'b0, 22'h0);
        rx(32'h33, 3'h3, 1'b1, 22'h32_0800);
        waitirq;
        chk("desc0", 32'h4008_0000, i_mem.mem[32'h100]);
        chk("desc1", 32'h8000_0000, i_mem.mem[32'h110]);
        chk("desc2", 32'h2329_800b, i_mem.mem[32'h120]);
        chk("data1", 32'h22, i_mem.mem[32'h404]);
        chk("data2", 32'h33, i_mem.mem[32'h500]);
        wb(1'b1, REG_ISTAT, 32'h1);
        rchk("ctrl", REG_CTRL, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        i_mem.mem[32'h100] = 32'h8000_0000;
        i_mem.mem[32'h104] = 32'hffc;
        i_mem.mem[32'h120] = 32'h8000_0000;
        wb(1'b1, REG_CTRL, 32'h5);
        for (int i = 0; i < 380; i++) rx(32'h1000 + i, 3'h4, i == 379, 22'h08_05dc);
        waitirq;
        chk("over", 32'h6214_05f0, i_mem.mem[32'h100]);
        chk("tail", 32'h117b, i_mem.mem[32'h9ec]);
        wb(1'b1, REG_ISTAT, 32'h7);
        rx(32'h55, 3'h4, 1'b1, 22'h01_0000);
        pollst(IRQ_DROP);
        chk("runt", 32'h8000_0000, i_mem.mem[32'h120]);
        rchk("cur", REG_CUR, 32'h120);
        wait (rrdy === 1'b1);
        rchk("state", REG_STATE, {28'h0, ST_DATA});
        print_verdict;
    end
endmodule
`default_nettype wire
